/* hdl/axis_stop_pkg.sv */
// Constants shared by the axis sensor and stop control logic.
// Assumes a single 50 MHz system clock and a 32-bit Wishbone slave.
package axis_stop_pkg;

    // Clock rate
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;

    // Register byte offsets
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_RUN = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CAUSE = 8'h0C;

    // Environment configuration fields
    localparam int LIMIT_ACTION_BIT = 3;
    localparam int SLOWDOWN_ACTION_BIT = 4;
    localparam int SLOWDOWN_LATCH_BIT = 5;
    localparam int SLOWDOWN_POL_BIT = 6;
    localparam int ORIGIN_POL_BIT = 7;
    localparam int ALARM_ACTION_BIT = 8;
    localparam int ALARM_POL_BIT = 9;
    localparam int CLEAR_ABRUPT_BIT = 10;
    localparam int CLEAR_HOME_BIT = 11;
    localparam int CLEAR_WIDTH_LSB = 12;
    localparam int CLEAR_WIDTH_MSB = 14;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_MASK = 32'h0000_7FF8;

    // Run setup register: run choice field in the low bits
    localparam int RUN_FIELD_W = 7;
    localparam logic [6:0] RUN_RESET = 7'h00;
    localparam logic [6:0] FEED_LIMIT_MASK = 7'h77;
    localparam logic [6:0] FEED_LIMIT_CODE = 7'h20;

    // Clear pulse width codes
    localparam logic [2:0] WIDTH_CODE_0 = 3'h0;
    localparam logic [2:0] WIDTH_CODE_1 = 3'h1;
    localparam logic [2:0] WIDTH_CODE_2 = 3'h2;

    // Clear pulse widths and their cycle counts
    localparam int CLEAR_W0_US = 12;
    localparam int CLEAR_W1_US = 102;
    localparam int CLEAR_W2_US = 409;
    localparam real CLEAR_W3_MS = 1.6;
    localparam int CLEAR_W0_CYC = CLEAR_W0_US * CLK_MHZ;
    localparam int CLEAR_W1_CYC = CLEAR_W1_US * CLK_MHZ;
    localparam int CLEAR_W2_CYC = CLEAR_W2_US * CLK_MHZ;
    localparam int CLEAR_W3_CYC = int'(CLEAR_W3_MS * 1000.0 * CLK_MHZ);

    // Stop cause bits in the cause register
    localparam int CAUSE_LIMIT_POS = 0;
    localparam int CAUSE_LIMIT_NEG = 1;
    localparam int CAUSE_ALARM = 2;
    localparam int CAUSE_EMERGENCY = 3;
    localparam int CAUSE_SLOWDOWN = 4;
    localparam int CAUSE_W = 5;

    // Axis stop tracker
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RUN = 4'b0010,
        ST_ABRUPT = 4'b0100,
        ST_DECEL = 4'b1000
    } axis_state_t;

endpackage

/* hdl/clear_pulse_gen.sv */
// Deviation-clear pulse generator with four selectable widths.
// Assumes fire is a one-cycle strobe in the system clock domain.
`timescale 1ns/1ps
module clear_pulse_gen
    import axis_stop_pkg::*;
#(
    parameter int CNT_W = 17,
    parameter int CYC_0 = CLEAR_W0_CYC,
    parameter int CYC_1 = CLEAR_W1_CYC,
    parameter int CYC_2 = CLEAR_W2_CYC,
    parameter int CYC_3 = CLEAR_W3_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Request
    input wire logic fire,
    input wire logic [2:0] widthCode,
    // Pulse
    output logic pulse_q
);

    if (CYC_0 < 1 || CYC_1 < 1 || CYC_2 < 1 || CYC_3 < 1 ||
        CYC_3 >= (1 << CNT_W) || CYC_2 >= (1 << CNT_W) ||
        CYC_1 >= (1 << CNT_W) || CYC_0 >= (1 << CNT_W)) begin : g_chk
        $error("clear_pulse_gen: width count out of range");
    end

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic [CNT_W-1:0] load;
    logic pulse_d;

    // Codes above two all give the longest width
    assign load = (widthCode == WIDTH_CODE_0) ? CNT_W'(CYC_0) :
                  (widthCode == WIDTH_CODE_1) ? CNT_W'(CYC_1) :
                  (widthCode == WIDTH_CODE_2) ? CNT_W'(CYC_2) :
                  CNT_W'(CYC_3);
    assign count_d = fire ? load - CNT_W'(1) :
                     (count_q != '0) ? count_q - CNT_W'(1) : count_q;
    assign pulse_d = fire || (count_q != '0);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
            pulse_q <= 1'b0;
        end else begin
            count_q <= count_d;
            pulse_q <= pulse_d;
        end
    end

endmodule

/* hdl/axis_sensor_stop_control.sv */
// Per-axis sensor handling, stop selection and deviation-clear output.
// Assumes sensor and pulse-core inputs are synchronous to sys_clk and
// that the pulse core reacts to the stop and slowdown request levels.
//
// Functional notes
// - Limit: bit 3 selects abrupt or decelerating stop
// - Slowdown: bit 4 selects slow only or stop
// - Bit 5 latches short slowdown pulses
// - Latch cleared when input inactive at start
// - Latch cleared while latch enable is zero
// - Bit 6 sets slowdown input polarity
// - Bit 7 sets origin input polarity
// - Alarm: bit 8 selects abrupt or decelerating stop
// - Bit 9 sets alarm input polarity
// - Bit 10: clear pulse after abrupt stops
// - No clear pulse after decelerating stops
// - Feed-to-limit mode still pulses on abrupt stop
// - Bit 11: clear pulse after origin return done
// - Bits 12 to 14 select clear pulse width
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module axis_sensor_stop_control
    import axis_stop_pkg::*;
#(
    parameter int CNT_W = 17,
    parameter int CLEAR_CYC_0 = CLEAR_W0_CYC,
    parameter int CLEAR_CYC_1 = CLEAR_W1_CYC,
    parameter int CLEAR_CYC_2 = CLEAR_W2_CYC,
    parameter int CLEAR_CYC_3 = CLEAR_W3_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // Sensor inputs
    input wire logic limitStopPosIn,
    input wire logic limitStopNegIn,
    input wire logic slowdownIn,
    input wire logic originIn,
    input wire logic alarmIn,
    input wire logic commonEmergencyIn,
    // Pulse core status
    input wire logic motionStart,
    input wire logic axisBusy,
    input wire logic moveDirNeg,
    input wire logic homeDone,
    // Requests to pulse core
    output logic abruptStop,
    output logic decelStop,
    output logic slowOnly,
    output logic originActive,
    // Servo driver
    output logic deviationClear
);

    // Pulse counter must fit a shift by its own width
    if (CNT_W < 2 || CNT_W > 30) begin : g_cnt_chk
        $error("axis_sensor_stop_control: counter width out of range");
    end

    // Configuration and run setup registers
    logic [31:0] config_q;
    logic [31:0] config_d;
    logic [RUN_FIELD_W-1:0] runChoice_q;
    logic [RUN_FIELD_W-1:0] runChoice_d;
    logic [CAUSE_W-1:0] cause_q;
    logic [CAUSE_W-1:0] cause_d;

    // Bus registers
    logic ack_q;
    logic [31:0] rdata_q;

    // Axis tracking
    axis_state_t state_q;
    axis_state_t state_d;
    logic slowLatch_q;
    logic slowLatch_d;
    logic abruptStop_q;
    logic decelStop_q;
    logic slowOnly_q;
    logic originActive_q;
    logic limitFault_q;
    logic limitFault_d;

    // Configuration fields
    wire limitActionChoice = config_q[LIMIT_ACTION_BIT];
    wire slowdownActionChoice = config_q[SLOWDOWN_ACTION_BIT];
    wire slowdownLatchEnable = config_q[SLOWDOWN_LATCH_BIT];
    wire slowdownPolarity = config_q[SLOWDOWN_POL_BIT];
    wire originPolarity = config_q[ORIGIN_POL_BIT];
    wire alarmActionChoice = config_q[ALARM_ACTION_BIT];
    wire alarmPolarity = config_q[ALARM_POL_BIT];
    wire clearOnAbruptStop = config_q[CLEAR_ABRUPT_BIT];
    wire clearOnHomeDone = config_q[CLEAR_HOME_BIT];
    wire [2:0] clearPulseWidth = config_q[CLEAR_WIDTH_MSB:CLEAR_WIDTH_LSB];

    // Internal active-high sensor levels
    wire slowdownActive = slowdownIn ~^ slowdownPolarity;
    wire originAct = originIn ~^ originPolarity;
    wire alarmActive = alarmIn ~^ alarmPolarity;

    // Only the limit ahead of the motion stops the axis
    wire limitPosHit = limitStopPosIn && !moveDirNeg;
    wire limitNegHit = limitStopNegIn && moveDirNeg;
    wire limitHit = limitPosHit || limitNegHit;

    // Feed-to-limit mode treats the limit as the normal end
    wire feedToLimit =
        (runChoice_q & FEED_LIMIT_MASK) == FEED_LIMIT_CODE;

    // Slowdown latch: set by the input, cleared at an idle start
    assign slowLatch_d =
        !slowdownLatchEnable ? 1'b0 :
        slowdownActive ? 1'b1 :
        motionStart ? 1'b0 :
        slowLatch_q;
    wire slowdownSeen = slowdownActive ||
                        (slowdownLatchEnable && slowLatch_q);

    // Stop decisions, ignored while the axis is at rest
    wire moving = axisBusy || motionStart;
    wire limitAbrupt = moving && limitHit && !limitActionChoice;
    wire limitDecel = moving && limitHit && limitActionChoice;
    wire alarmAbrupt = moving && alarmActive && !alarmActionChoice;
    wire alarmDecel = moving && alarmActive && alarmActionChoice;
    wire emergencyAbrupt = moving && commonEmergencyIn;
    wire slowdownDecel = moving && slowdownSeen && slowdownActionChoice;
    wire abruptCause = limitAbrupt || alarmAbrupt || emergencyAbrupt;
    wire decelCause = limitDecel || alarmDecel || slowdownDecel;
    wire slowOnlyCause = slowdownSeen && !slowdownActionChoice;

    // Stop tracker
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (motionStart) begin
                    state_d = abruptCause ? ST_ABRUPT :
                              decelCause ? ST_DECEL : ST_RUN;
                end
            end
            ST_RUN: begin
                if (abruptCause) begin
                    state_d = ST_ABRUPT;
                end else if (decelCause) begin
                    state_d = ST_DECEL;
                end else if (!axisBusy) begin
                    state_d = ST_IDLE;
                end
            end
            ST_DECEL: begin
                if (abruptCause) begin
                    state_d = ST_ABRUPT;
                end else if (!axisBusy) begin
                    state_d = ST_IDLE;
                end
            end
            ST_ABRUPT: begin
                if (!axisBusy) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // Clear pulse triggers
    wire abruptEnded = (state_q == ST_ABRUPT) && !axisBusy;
    wire decelEnded = (state_q == ST_DECEL) && !axisBusy;
    wire clearFire =
        (abruptEnded && clearOnAbruptStop) ||
        (homeDone && clearOnHomeDone);
    // A decelerating end never reaches clearFire by itself
    wire decelQuiet = decelEnded;

    // Limit error flag: limit stops outside feed-to-limit mode
    // A hit at the start of a motion still sets the flag
    assign limitFault_d = (!motionStart && limitFault_q) ||
        (moving && limitHit && !feedToLimit);

    // Sticky stop causes, set wins over a write-one clear
    wire [CAUSE_W-1:0] causeNow;
    assign causeNow[CAUSE_LIMIT_POS] = moving && limitPosHit;
    assign causeNow[CAUSE_LIMIT_NEG] = moving && limitNegHit;
    assign causeNow[CAUSE_ALARM] = moving && alarmActive;
    assign causeNow[CAUSE_EMERGENCY] = moving && commonEmergencyIn;
    assign causeNow[CAUSE_SLOWDOWN] = moving && slowdownSeen;

    // Bus decode
    wire busReq = wb_cyc_i && wb_stb_i && !ack_q;
    wire busWrite = busReq && wb_we_i;
    wire selConfig = wb_adr_i == ADDR_CONFIG;
    wire selRun = wb_adr_i == ADDR_RUN;
    wire selStatus = wb_adr_i == ADDR_STATUS;
    wire selCause = wb_adr_i == ADDR_CAUSE;

    // Byte-lane write mask
    wire [31:0] laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wrMasked = wb_dat_i & laneMask;

    assign config_d = (busWrite && selConfig) ?
        (((config_q & ~laneMask) | wrMasked) & CONFIG_MASK) : config_q;
    assign runChoice_d = (busWrite && selRun && wb_sel_i[0]) ?
        wb_dat_i[RUN_FIELD_W-1:0] : runChoice_q;

    wire [CAUSE_W-1:0] causeClr = (busWrite && selCause) ?
        wrMasked[CAUSE_W-1:0] : '0;
    assign cause_d = (cause_q & ~causeClr) | causeNow;

    // Status word
    wire [31:0] statusWord = {
        18'h0,
        limitFault_q,
        deviationClear,
        commonEmergencyIn,
        alarmActive,
        originAct,
        slowdownActive,
        limitStopNegIn,
        limitStopPosIn,
        slowLatch_q,
        slowOnly_q,
        decelStop_q,
        abruptStop_q,
        axisBusy,
        state_q != ST_IDLE
    };

    // Read mux, unmapped addresses read zero
    wire [31:0] rdata_d =
        selConfig ? config_q :
        selRun ? {{(32 - RUN_FIELD_W){1'b0}}, runChoice_q} :
        selStatus ? statusWord :
        selCause ? {{(32 - CAUSE_W){1'b0}}, cause_q} :
        32'h0000_0000;

    // Request levels to the pulse core
    wire abruptStop_d = (state_d == ST_ABRUPT) && moving;
    wire decelStop_d = (state_d == ST_DECEL) && moving;
    wire slowOnly_d = moving && slowOnlyCause &&
                      (state_d == ST_RUN);

    // Registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            config_q <= CONFIG_RESET;
            runChoice_q <= RUN_RESET;
            cause_q <= '0;
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            config_q <= config_d;
            runChoice_q <= runChoice_d;
            cause_q <= cause_d;
            ack_q <= busReq;
            rdata_q <= busReq ? rdata_d : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            slowLatch_q <= 1'b0;
            limitFault_q <= 1'b0;
        end else begin
            state_q <= state_d;
            slowLatch_q <= slowLatch_d;
            limitFault_q <= limitFault_d;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            abruptStop_q <= 1'b0;
            decelStop_q <= 1'b0;
            slowOnly_q <= 1'b0;
            originActive_q <= 1'b0;
        end else begin
            abruptStop_q <= abruptStop_d;
            decelStop_q <= decelStop_d;
            slowOnly_q <= slowOnly_d;
            originActive_q <= originAct;
        end
    end

    // Deviation-clear pulse
    clear_pulse_gen #(
        .CNT_W(CNT_W),
        .CYC_0(CLEAR_CYC_0),
        .CYC_1(CLEAR_CYC_1),
        .CYC_2(CLEAR_CYC_2),
        .CYC_3(CLEAR_CYC_3)
    ) u_clear (
        .sys_clk(sys_clk),
        .reset(reset),
        .fire(clearFire && !(decelQuiet && !homeDone)),
        .widthCode(clearPulseWidth),
        .pulse_q(deviationClear)
    );

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign abruptStop = abruptStop_q;
    assign decelStop = decelStop_q;
    assign slowOnly = slowOnly_q;
    assign originActive = originActive_q;

endmodule

/* tb/axis_stop_properties.sv */
// Checker for the bus answer, stop requests and clear pulse.
// Bound into every axis_sensor_stop_control; sees its ports only.
`timescale 1ns/1ps
module axis_stop_properties
    import axis_stop_pkg::*;
#(
    parameter int CLEAR_CYC_0 = CLEAR_W0_CYC,
    parameter int CLEAR_CYC_1 = CLEAR_W1_CYC,
    parameter int CLEAR_CYC_2 = CLEAR_W2_CYC,
    parameter int CLEAR_CYC_3 = CLEAR_W3_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Motion
    input wire logic motionStart,
    input wire logic axisBusy,
    input wire logic homeDone,
    input wire logic abruptStop,
    input wire logic decelStop,
    input wire logic deviationClear
);
    int cnt;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt <= 0;
        end else begin
            cnt <= deviationClear ? cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("request not answered");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_abrupt_hold: assert property (
        abruptStop && axisBusy |=> abruptStop)
        else $error("abrupt stop dropped while moving");
    a_abrupt_end: assert property (
        abruptStop && !axisBusy && !motionStart |=> !abruptStop)
        else $error("abrupt stop held at rest");
    a_stop_excl: assert property (abruptStop |-> !decelStop)
        else $error("both stop kinds requested");
    a_stop_moving: assert property (
        $rose(abruptStop) || $rose(decelStop)
        |-> $past(axisBusy) || $past(motionStart))
        else $error("stop requested while idle");
    a_clear_cause: assert property ($rose(deviationClear)
        |-> $past(abruptStop) || $past(homeDone))
        else $error("clear pulse without cause");
    a_clear_width: assert property ($fell(deviationClear)
        |-> cnt inside {CLEAR_CYC_0, CLEAR_CYC_1, CLEAR_CYC_2, CLEAR_CYC_3})
        else $error("clear pulse width off");
endmodule

bind axis_sensor_stop_control axis_stop_properties #(
    .CLEAR_CYC_0(CLEAR_CYC_0), .CLEAR_CYC_1(CLEAR_CYC_1),
    .CLEAR_CYC_2(CLEAR_CYC_2), .CLEAR_CYC_3(CLEAR_CYC_3)
) u_axis_stop_properties (.sys_clk(sys_clk), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .motionStart(motionStart), .axisBusy(axisBusy),
    .homeDone(homeDone), .abruptStop(abruptStop), .decelStop(decelStop),
    .deviationClear(deviationClear));

/* tb/servo_model.sv */
// Servo driver stand-in: measures each deviation-clear pulse.
// Assumes the pulse is synchronous to sys_clk.
`timescale 1ns/1ps
module servo_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Clear input
    input wire logic deviationClear,
    // Measurement
    output int pulseWidth,
    output int pulseCount
);
    int run;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            run <= 0;
            pulseWidth <= 0;
            pulseCount <= 0;
        end else if (deviationClear) begin
            run <= run + 1;
        end else if (run != 0) begin
            pulseWidth <= run;
            pulseCount <= pulseCount + 1;
            run <= 0;
        end
    end
endmodule

/* tb/tb.sv */
// Bench for the axis stop block with shortened clear widths.
// Assumes the servo_model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb;
    import axis_stop_pkg::*;
    localparam logic [31:0] BASE = 32'h0000_02C0;
    logic sys_clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, ack;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    logic posIn = 0, negIn = 0, slowIn = 0, originSig = 0, alarmSig = 0;
    logic emgIn = 0;
    logic mStart = 0, busy = 0, dirNeg = 0, homeDone = 0;
    logic abruptStop, decelStop, slowOnly, originActive, deviationClear;
    int pulseWidth, pulseCount, n_fail = 0, samples_checked = 0;
    int cw [5] = '{3, 5, 7, 9, 9};

    always #10 sys_clk = ~sys_clk;

    axis_sensor_stop_control #(.CLEAR_CYC_0(3), .CLEAR_CYC_1(5),
        .CLEAR_CYC_2(7), .CLEAR_CYC_3(9)) u_axis_sensor_stop_control (
        .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_ack_o(ack), .wb_dat_o(rdat), .limitStopPosIn(posIn),
        .limitStopNegIn(negIn), .slowdownIn(slowIn), .originIn(originSig),
        .alarmIn(alarmSig), .commonEmergencyIn(emgIn), .motionStart(mStart),
        .axisBusy(busy), .moveDirNeg(dirNeg), .homeDone(homeDone),
        .abruptStop(abruptStop), .decelStop(decelStop), .slowOnly(slowOnly),
        .originActive(originActive), .deviationClear(deviationClear));
    servo_model u_servo_model (.sys_clk(sys_clk), .reset(reset),
        .deviationClear(deviationClear), .pulseWidth(pulseWidth),
        .pulseCount(pulseCount));

    task close_out;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // One classic cycle, held until ack is sampled
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        do @(posedge sys_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 0; stb <= 0;
    endtask
    task motion;
        @(posedge sys_clk);
        mStart <= 1; busy <= 1;
        @(posedge sys_clk);
        mStart <= 0;
    endtask
    task pol_case(input logic p, input logic act);
        @(posedge sys_clk);
        slowIn <= p ~^ act; originSig <= p ~^ act; alarmSig <= p ~^ act;
        tick(2);
        chk("origin active", act, originActive);
        bus(0, ADDR_STATUS, 0);
        chk("slowdown active", act, q[8]);
        chk("alarm active", act, q[10]);
    endtask
    task clr_chk(input int c0, input int w);
        chk("clear count", c0 + (w != 0), pulseCount);
        if (w != 0) chk("clear width", w, pulseWidth);
    endtask
    task stop_case(input logic [31:0] cfg, input int src, input logic ab,
                   input int w);
        int c0;
        bus(1, ADDR_CONFIG, cfg);
        c0 = pulseCount;
        dirNeg <= (src == 1);
        motion();
        posIn <= (src == 0); negIn <= (src == 1);
        alarmSig <= (src == 2); emgIn <= (src == 3);
        tick(3);
        chk("abrupt stop", ab, abruptStop);
        chk("decel stop", !ab, decelStop);
        busy <= 0; posIn <= 0; negIn <= 0; alarmSig <= 0; emgIn <= 0;
        tick(14);
        clr_chk(c0, w);
    endtask
    task home_case(input logic [31:0] cfg, input int w);
        int c0;
        bus(1, ADDR_CONFIG, cfg);
        c0 = pulseCount;
        @(posedge sys_clk);
        homeDone <= 1;
        @(posedge sys_clk);
        homeDone <= 0;
        tick(12);
        clr_chk(c0, w);
    endtask

    initial begin
        tick(4);
        reset <= 0;
        bus(0, ADDR_CONFIG, 0);
        chk("config reset", CONFIG_RESET, q);
        bus(1, ADDR_CONFIG, 32'hFFFF_FFFF);
        bus(0, ADDR_CONFIG, 0);
        chk("config mask", CONFIG_MASK, q);
        bus(0, 8'h10, 0);
        chk("unmapped read", 32'h0, q);
        for (int p = 0; p < 2; p++) begin
            bus(1, ADDR_CONFIG, p ? BASE : 32'h0);
            pol_case(p, 1);
            pol_case(p, 0);
        end
        for (int k = 0; k < 5; k++) begin
            stop_case(BASE | 32'h400 | (k << 12), k % 4, 1,
                      cw[k]);
        end
        stop_case(BASE | 32'h408, 0, 0, 0);
        stop_case(BASE | 32'h500, 2, 0, 0);
        stop_case(BASE, 3, 1, 0);
        bus(1, ADDR_RUN, {25'h0, FEED_LIMIT_CODE});
        stop_case(BASE | 32'h400, 0, 1, cw[0]);
        bus(1, ADDR_CONFIG, BASE | 32'h20);
        motion();
        @(posedge sys_clk) slowIn <= 1;
        @(posedge sys_clk) slowIn <= 0;
        tick(3);
        chk("latched slow", 1, slowOnly);
        bus(1, ADDR_CONFIG, BASE);
        tick(2);
        chk("slow unlatched", 0, slowOnly);
        bus(1, ADDR_CONFIG, BASE | 32'h20);
        @(posedge sys_clk) slowIn <= 1;
        @(posedge sys_clk) slowIn <= 0;
        tick(3);
        busy <= 0;
        tick(2);
        motion();
        tick(3);
        chk("slow after start", 0, slowOnly);
        bus(1, ADDR_CONFIG, BASE);
        slowIn <= 1;
        tick(3);
        chk("slow only", 1, slowOnly);
        chk("no decel", 0, decelStop);
        slowIn <= 0;
        bus(1, ADDR_CONFIG, BASE | 32'h10);
        slowIn <= 1;
        tick(3);
        chk("slowdown stop", 1, decelStop);
        slowIn <= 0; busy <= 0;
        tick(4);
        home_case(BASE | 32'h1800, cw[1]);
        home_case(BASE | 32'h1000, 0);
        bus(0, ADDR_CAUSE, 0);
        chk("stop causes", 32'h0000_001F, q);
        bus(1, ADDR_CAUSE, 32'h0000_001F);
        bus(0, ADDR_CAUSE, 0);
        chk("causes cleared", 32'h0000_0000, q);
        close_out();
    end

    initial begin
        repeat (8000) @(posedge sys_clk);
        n_fail++;
        close_out();
    end
endmodule
